// *** rtl/bfc_alu.sv ***
// data path of the bit, shift and swap operations
`timescale 1ns/1ps
module bfc_alu
	import bfc_pkg::*;
(
	input wire bfc_op_t op_i, // operation
	input wire logic [2:0] sel_i, // bit index
	input wire logic [7:0] src_i, // register operand
	input wire logic t_i, // transfer flag
	output logic [7:0] result_o, // value to write back
	output logic result_we_o, // write back wanted
	output logic bit_o, // selected source bit
	output logic [3:0] shift_flags_o // v n z c of shift
);
	logic [7:0] ins;
	logic [7:0] shr_res;

	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_ins
			assign ins[i] = (sel_i == 3'(i)) ? t_i : src_i[i];
		end
	endgenerate

	assign shr_res = {src_i[7], src_i[7:1]};
	assign bit_o = src_i[sel_i];
	assign shift_flags_o = {src_i[7] ^ src_i[0], src_i[7], shr_res == 8'h00, src_i[0]};

	always_comb
	begin
		result_o = src_i;
		result_we_o = 1'b0;
		case (op_i)
			arith_shift_right_op:
			begin
				result_o = shr_res;
				result_we_o = 1'b1;
			end
			nibble_swap_op:
			begin
				result_o = {src_i[3:0], src_i[7:4]};
				result_we_o = 1'b1;
			end
			transfer_flag_to_bit_op:
			begin
				result_o = ins;
				result_we_o = 1'b1;
			end
			default:
			begin
				result_o = src_i;
				result_we_o = 1'b0;
			end
		endcase
	end
endmodule

// *** rtl/bfc_consts.svh ***
// bit positions, register offsets and reset values of the flag-control block
`ifndef BFC_CONSTS_SVH
`define BFC_CONSTS_SVH
`define BFC_FLAG_C 0
`define BFC_FLAG_Z 1
`define BFC_FLAG_N 2
`define BFC_FLAG_V 3
`define BFC_FLAG_S 4
`define BFC_FLAG_H 5
`define BFC_FLAG_T 6
`define BFC_FLAG_I 7
`define BFC_FLAGS_RST 8'h00
`define BFC_ADDR_FLAGS 2'h0
`define BFC_ADDR_RESULT 2'h1
`define BFC_ADDR_STATUS 2'h2
`define BFC_ADDR_CTRL 2'h3
`define BFC_STAT_HALT 1
`define BFC_STAT_SLEEP 2
`define BFC_STAT_WDOG 3
`define BFC_STAT_BRK 4
`define BFC_CTRL_DBG 0
`define BFC_CTRL_RST 1'b0
`define BFC_RESULT_RST 8'h00
`endif

// *** rtl/bfc_exec.sv ***
// execution of bit, flag and core-control operations
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "bfc_consts.svh"
// Function
// - bit store copies source bit into T
// - bit load writes T into register bit
// - overflow raise sets V only
// - overflow drop clears V only
// - sign raise sets S only
// - sign drop clears S only
// - half carry drop clears H only
// - sleep pulses sleep request, flags kept
// - watchdog restart pulses, flags kept
// - break acts only with debug enabled
module bfc_exec
	import bfc_pkg::*;
(
	input wire logic clk_i, // 40 MHz clock
	input wire logic resetn_i, // sync reset, active low
	input wire logic en_i, // clock enable
	input wire logic op_valid_i, // operation offered
	input wire bfc_op_t op_i, // operation code
	input wire logic [2:0] op_sel_i, // bit or flag index
	input wire logic [7:0] src_i, // register operand
	input wire logic dbg_resume_i, // debugger resumes core
	input wire logic [1:0] bus_addr_i, // register address
	input wire logic [7:0] bus_wdata_i, // write data
	input wire logic bus_wr_i, // write strobe
	input wire logic bus_rd_i, // read strobe
	output logic [7:0] bus_rdata_o, // read data, cycle after strobe
	output logic op_ready_o, // operation can be taken
	output logic [7:0] flags_o, // status flags register
	output logic [7:0] wb_data_o, // write back value
	output logic wb_we_o, // write back pulse
	output logic sleep_req_o, // sleep entry pulse
	output logic wdog_restart_o, // watchdog restart pulse
	output logic break_halt_o // core halted by break
);
	localparam bfc_regs_t RST = '{
		state: bfc_run,
		ready: 1'b1,
		flags: `BFC_FLAGS_RST,
		result: `BFC_RESULT_RST,
		dbg_en: `BFC_CTRL_RST,
		default: '0
	};

	bfc_regs_t st_r;
	bfc_regs_t st_nxt;
	logic take;
	logic [7:0] flags_base;
	logic [7:0] alu_res;
	logic alu_we;
	logic alu_bit;
	logic [3:0] sh_flags;

	bfc_alu u_alu (
		.op_i(op_i),
		.sel_i(op_sel_i),
		.src_i(src_i),
		.t_i(st_r.flags[`BFC_FLAG_T]),
		.result_o(alu_res),
		.result_we_o(alu_we),
		.bit_o(alu_bit),
		.shift_flags_o(sh_flags)
	);

	// halted core refuses operations; ready is registered, so no comb path to op_valid_i
	assign take = en_i && op_valid_i && st_r.ready;

	// software write lands first; an operation in the same cycle overrides its own bits
	assign flags_base = (bus_wr_i && bus_addr_i == `BFC_ADDR_FLAGS) ? bus_wdata_i : st_r.flags;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.flags = flags_base;
		st_nxt.wb_we = 1'b0;
		st_nxt.sleep = 1'b0;
		st_nxt.wdog = 1'b0;
		st_nxt.brk = 1'b0;
		st_nxt.rdata = 8'h00;
		if (bus_wr_i && bus_addr_i == `BFC_ADDR_CTRL)
			st_nxt.dbg_en = bus_wdata_i[`BFC_CTRL_DBG];
		// write one to clear; an event in the same cycle still sets
		if (bus_wr_i && bus_addr_i == `BFC_ADDR_STATUS)
			st_nxt.seen = st_r.seen & ~bus_wdata_i;
		if (take)
		begin
			if (alu_we)
			begin
				st_nxt.wb_data = alu_res;
				st_nxt.wb_we = 1'b1;
				st_nxt.result = alu_res;
			end
			case (op_i)
				bit_to_transfer_flag_op:
					st_nxt.flags[`BFC_FLAG_T] = alu_bit;
				generic_flag_raise_op:
					st_nxt.flags[op_sel_i] = 1'b1;
				generic_flag_drop_op:
					st_nxt.flags[op_sel_i] = 1'b0;
				carry_raise_op:
					st_nxt.flags[`BFC_FLAG_C] = 1'b1;
				carry_drop_op:
					st_nxt.flags[`BFC_FLAG_C] = 1'b0;
				negative_raise_op:
					st_nxt.flags[`BFC_FLAG_N] = 1'b1;
				negative_drop_op:
					st_nxt.flags[`BFC_FLAG_N] = 1'b0;
				zero_flag_raise_op:
					st_nxt.flags[`BFC_FLAG_Z] = 1'b1;
				zero_flag_drop_op:
					st_nxt.flags[`BFC_FLAG_Z] = 1'b0;
				global_irq_enable_op:
					st_nxt.flags[`BFC_FLAG_I] = 1'b1;
				global_irq_disable_op:
					st_nxt.flags[`BFC_FLAG_I] = 1'b0;
				transfer_flag_raise_op:
					st_nxt.flags[`BFC_FLAG_T] = 1'b1;
				transfer_flag_drop_op:
					st_nxt.flags[`BFC_FLAG_T] = 1'b0;
				sign_flag_raise_op:
					st_nxt.flags[`BFC_FLAG_S] = 1'b1;
				sign_flag_drop_op:
					st_nxt.flags[`BFC_FLAG_S] = 1'b0;
				overflow_flag_raise_op:
					st_nxt.flags[`BFC_FLAG_V] = 1'b1;
				overflow_flag_drop_op:
					st_nxt.flags[`BFC_FLAG_V] = 1'b0;
				half_carry_drop_op:
					st_nxt.flags[`BFC_FLAG_H] = 1'b0;
				arith_shift_right_op:
				begin
					st_nxt.flags[`BFC_FLAG_V] = sh_flags[3];
					st_nxt.flags[`BFC_FLAG_N] = sh_flags[2];
					st_nxt.flags[`BFC_FLAG_Z] = sh_flags[1];
					st_nxt.flags[`BFC_FLAG_C] = sh_flags[0];
				end
				sleep_op:
				begin
					st_nxt.sleep = 1'b1;
					st_nxt.seen[`BFC_STAT_SLEEP] = 1'b1;
				end
				watchdog_restart_op:
				begin
					st_nxt.wdog = 1'b1;
					st_nxt.seen[`BFC_STAT_WDOG] = 1'b1;
				end
				debug_break_op:
				begin
					// without debug enabled the break is a plain no-op
					if (st_r.dbg_en)
					begin
						st_nxt.brk = 1'b1;
						st_nxt.seen[`BFC_STAT_BRK] = 1'b1;
					end
				end
				default:
				begin
				end
			endcase
		end
		case (st_r.state)
			bfc_run:
				if (take && op_i == debug_break_op && st_r.dbg_en)
					st_nxt.state = bfc_halt;
			bfc_halt:
				if (dbg_resume_i)
					st_nxt.state = bfc_run;
			default:
				st_nxt.state = bfc_run;
		endcase
		st_nxt.ready = (st_nxt.state == bfc_run);
		if (bus_rd_i)
		begin
			case (bus_addr_i)
				`BFC_ADDR_FLAGS: st_nxt.rdata = st_r.flags;
				`BFC_ADDR_RESULT: st_nxt.rdata = st_r.result;
				`BFC_ADDR_STATUS:
				begin
					st_nxt.rdata = st_r.seen;
					st_nxt.rdata[`BFC_STAT_HALT] = (st_r.state == bfc_halt);
				end
				default: st_nxt.rdata = {7'h00, st_r.dbg_en};
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			st_r <= RST;
		else if (en_i)
			st_r <= st_nxt;
	end

	assign bus_rdata_o = st_r.rdata;
	assign op_ready_o = st_r.ready;
	assign flags_o = st_r.flags;
	assign wb_data_o = st_r.wb_data;
	assign wb_we_o = st_r.wb_we;
	assign sleep_req_o = st_r.sleep;
	assign wdog_restart_o = st_r.wdog;
	assign break_halt_o = (st_r.state == bfc_halt);

	// helpers seen only by the checks
	localparam logic [7:0] M_T = 8'h01 << `BFC_FLAG_T;
	localparam logic [7:0] M_V = 8'h01 << `BFC_FLAG_V;
	localparam logic [7:0] M_S = 8'h01 << `BFC_FLAG_S;
	localparam logic [7:0] M_H = 8'h01 << `BFC_FLAG_H;
	logic sel_bit;
	logic [7:0] shr_exp;
	logic [7:0] swap_exp;
	logic sleep_take;
	logic wdog_take;
	assign sel_bit = src_i[op_sel_i];
	assign shr_exp = {src_i[7], src_i[7:1]};
	assign swap_exp = {src_i[3:0], src_i[7:4]};
	// a pulse may stand on: same op taken again, or clock enable low
	assign sleep_take = take && op_i == sleep_op;
	assign wdog_take = take && op_i == watchdog_restart_op;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_bit_store;
		take && op_i == bit_to_transfer_flag_op |=>
			flags_o[`BFC_FLAG_T] == $past(sel_bit) &&
			(flags_o & ~M_T) == ($past(flags_base) & ~M_T);
	endproperty
	a_bit_store: assert property (p_bit_store) else $error("bit store wrong");

	property p_bit_load;
		take && op_i == transfer_flag_to_bit_op |=>
			wb_we_o && wb_data_o[$past(op_sel_i)] == $past(st_r.flags[`BFC_FLAG_T]) &&
			flags_o == $past(flags_base);
	endproperty
	a_bit_load: assert property (p_bit_load) else $error("bit load wrong");

	property p_ovf_raise;
		take && op_i == overflow_flag_raise_op |=>
			flags_o == ($past(flags_base) | M_V);
	endproperty
	a_ovf_raise: assert property (p_ovf_raise) else $error("overflow raise wrong");

	property p_ovf_drop;
		take && op_i == overflow_flag_drop_op |=>
			flags_o == ($past(flags_base) & ~M_V);
	endproperty
	a_ovf_drop: assert property (p_ovf_drop) else $error("overflow drop wrong");

	property p_sign_raise;
		take && op_i == sign_flag_raise_op |=>
			flags_o == ($past(flags_base) | M_S);
	endproperty
	a_sign_raise: assert property (p_sign_raise) else $error("sign raise wrong");

	property p_sign_drop;
		take && op_i == sign_flag_drop_op |=>
			flags_o == ($past(flags_base) & ~M_S);
	endproperty
	a_sign_drop: assert property (p_sign_drop) else $error("sign drop wrong");

	property p_half_drop;
		take && op_i == half_carry_drop_op |=>
			flags_o == ($past(flags_base) & ~M_H);
	endproperty
	a_half_drop: assert property (p_half_drop) else $error("half carry drop wrong");

	property p_sleep;
		sleep_take |=>
			sleep_req_o && flags_o == $past(flags_base) ##1
			(!sleep_req_o || !$past(en_i) || $past(sleep_take));
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep pulse wrong");

	property p_wdog;
		wdog_restart_o |-> !$past(en_i) ||
			($past(wdog_take) && flags_o == $past(flags_base));
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog restart wrong");

	property p_brk;
		take && op_i == debug_break_op |=>
			break_halt_o == $past(st_r.dbg_en) && !op_ready_o == $past(st_r.dbg_en) &&
			flags_o == $past(flags_base);
	endproperty
	a_brk: assert property (p_brk) else $error("break handling wrong");

	property p_flag;
		take && op_i == generic_flag_raise_op |=>
			flags_o[$past(op_sel_i)] && !wb_we_o;
	endproperty
	a_flag: assert property (p_flag) else $error("generic raise wrong");

	property p_shr;
		take && op_i == arith_shift_right_op |=>
			wb_we_o && wb_data_o == $past(shr_exp) &&
			flags_o[`BFC_FLAG_C] == $past(src_i[0]) &&
			flags_o[`BFC_FLAG_V] == (wb_data_o[7] ^ flags_o[`BFC_FLAG_C]);
	endproperty
	a_shr: assert property (p_shr) else $error("shift right wrong");

	property p_swap;
		take && op_i == nibble_swap_op |=>
			wb_data_o == $past(swap_exp) && flags_o == $past(flags_base);
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	c_bit_store: cover property (take && op_i == bit_to_transfer_flag_op);
	c_halt: cover property (take && op_i == debug_break_op && st_r.dbg_en ##[1:20] op_ready_o);
	c_sleep: cover property (sleep_req_o);
	c_shr: cover property (take && op_i == arith_shift_right_op ##1 flags_o[`BFC_FLAG_Z]);
endmodule

// *** rtl/bfc_pkg.sv ***
// types of the flag-control block
package bfc_pkg;
	typedef enum logic [4:0] {
		no_operation_op,
		bit_to_transfer_flag_op,
		transfer_flag_to_bit_op,
		generic_flag_raise_op,
		generic_flag_drop_op,
		carry_raise_op,
		carry_drop_op,
		negative_raise_op,
		negative_drop_op,
		zero_flag_raise_op,
		zero_flag_drop_op,
		global_irq_enable_op,
		global_irq_disable_op,
		sign_flag_raise_op,
		sign_flag_drop_op,
		overflow_flag_raise_op,
		overflow_flag_drop_op,
		transfer_flag_raise_op,
		transfer_flag_drop_op,
		half_carry_drop_op,
		arith_shift_right_op,
		nibble_swap_op,
		sleep_op,
		watchdog_restart_op,
		debug_break_op
	} bfc_op_t;

	typedef enum logic [0:0] {
		bfc_run,
		bfc_halt
	} bfc_state_t;

	typedef struct packed {
		bfc_state_t state;
		logic ready;
		logic [7:0] flags;
		logic [7:0] result;
		logic [7:0] wb_data;
		logic wb_we;
		logic sleep;
		logic wdog;
		logic brk;
		logic dbg_en;
		logic [7:0] seen;
		logic [7:0] rdata;
	} bfc_regs_t;
endpackage

// *** sim/bfc_exec_test.sv ***
// self-checking bench of the flag-control execution block
`timescale 1ns/1ps
module bfc_exec_test
	import bfc_pkg::*;
;
	typedef struct packed {
		bfc_op_t op;
		logic [2:0] sel;
		logic [7:0] src;
		logic [7:0] pre;
		logic [7:0] flags;
		logic [3:0] outs;
		logic [7:0] wb;
	} bfc_row_t;
	// outs: write back, sleep, watchdog, halt
	localparam bfc_row_t rows [26] = '{
		'{no_operation_op,3'h0,8'h00,8'ha5,8'ha5,4'h0,8'h00},
		'{bit_to_transfer_flag_op,3'h3,8'hf7,8'hff,8'hbf,4'h0,8'h00},
		'{transfer_flag_to_bit_op,3'h5,8'h00,8'h40,8'h40,4'h8,8'h20},
		'{generic_flag_raise_op,3'h5,8'h00,8'h00,8'h20,4'h0,8'h00},
		'{generic_flag_drop_op,3'h7,8'h00,8'hff,8'h7f,4'h0,8'h00},
		'{carry_raise_op,3'h0,8'h00,8'h00,8'h01,4'h0,8'h00},
		'{carry_drop_op,3'h0,8'h00,8'hff,8'hfe,4'h0,8'h00},
		'{negative_raise_op,3'h0,8'h00,8'h00,8'h04,4'h0,8'h00},
		'{negative_drop_op,3'h0,8'h00,8'hff,8'hfb,4'h0,8'h00},
		'{zero_flag_raise_op,3'h0,8'h00,8'h00,8'h02,4'h0,8'h00},
		'{zero_flag_drop_op,3'h0,8'h00,8'hff,8'hfd,4'h0,8'h00},
		'{global_irq_enable_op,3'h0,8'h00,8'h00,8'h80,4'h0,8'h00},
		'{global_irq_disable_op,3'h0,8'h00,8'hff,8'h7f,4'h0,8'h00},
		'{sign_flag_raise_op,3'h0,8'h00,8'h00,8'h10,4'h0,8'h00},
		'{sign_flag_drop_op,3'h0,8'h00,8'hff,8'hef,4'h0,8'h00},
		'{overflow_flag_raise_op,3'h0,8'h00,8'h00,8'h08,4'h0,8'h00},
		'{overflow_flag_drop_op,3'h0,8'h00,8'hff,8'hf7,4'h0,8'h00},
		'{transfer_flag_raise_op,3'h0,8'h00,8'h00,8'h40,4'h0,8'h00},
		'{transfer_flag_drop_op,3'h0,8'h00,8'hff,8'hbf,4'h0,8'h00},
		'{half_carry_drop_op,3'h0,8'h00,8'hff,8'hdf,4'h0,8'h00},
		'{arith_shift_right_op,3'h0,8'h81,8'h00,8'h05,4'h8,8'hc0},
		'{arith_shift_right_op,3'h0,8'h01,8'hf0,8'hfb,4'h8,8'h00},
		'{sleep_op,3'h0,8'h00,8'h33,8'h33,4'h4,8'h00},
		'{watchdog_restart_op,3'h0,8'h00,8'hcc,8'hcc,4'h2,8'h00},
		'{debug_break_op,3'h0,8'h00,8'h11,8'h11,4'h0,8'h00},
		'{nibble_swap_op,3'h0,8'h3c,8'h5a,8'h5a,4'h8,8'hc3}
	};
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic en_i = 1'b1;
	logic op_valid_i = 1'b0;
	bfc_op_t op_i = no_operation_op;
	logic [2:0] op_sel_i = 3'h0;
	logic [7:0] src_i = 8'h00;
	logic dbg_resume_i = 1'b0;
	logic [1:0] bus_addr_i = 2'h0;
	logic [7:0] bus_wdata_i = 8'h00;
	logic bus_wr_i = 1'b0;
	logic bus_rd_i = 1'b0;
	logic [7:0] bus_rdata_o;
	logic op_ready_o;
	logic [7:0] flags_o;
	logic [7:0] wb_data_o;
	logic wb_we_o;
	logic sleep_req_o;
	logic wdog_restart_o;
	logic break_halt_o;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	wire [7:0] outs_w = {4'h0, wb_we_o, sleep_req_o, wdog_restart_o, break_halt_o};

	bfc_exec dut (.clk_i(clk_i), .resetn_i(resetn_i), .en_i(en_i), .op_valid_i(op_valid_i),
		.op_i(op_i), .op_sel_i(op_sel_i), .src_i(src_i), .dbg_resume_i(dbg_resume_i),
		.bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
		.bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .op_ready_o(op_ready_o),
		.flags_o(flags_o), .wb_data_o(wb_data_o), .wb_we_o(wb_we_o), .sleep_req_o(sleep_req_o),
		.wdog_restart_o(wdog_restart_o), .break_halt_o(break_halt_o));

	always #12.5 clk_i = ~clk_i;

	task automatic conclude();
		$display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// the whole run needs well under a thousand cycles
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			bad_count++;
			conclude();
		end
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h0, got}, {7'h0, exp});
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_addr_i <= a;
		bus_wdata_i <= d;
		bus_wr_i <= 1'b1;
		@(posedge clk_i);
		bus_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		bus_addr_i <= a;
		bus_rd_i <= 1'b1;
		@(posedge clk_i);
		bus_rd_i <= 1'b0;
		#1;
		chk8(bus_rdata_o, exp);
	endtask

	// returns just after the taking edge has landed
	task automatic do_op(input bfc_op_t o, input logic [2:0] s, input logic [7:0] d);
		@(posedge clk_i);
		op_valid_i <= 1'b1;
		op_i <= o;
		op_sel_i <= s;
		src_i <= d;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		#1;
	endtask

	task automatic chk_reset();
		chk8(flags_o, 8'h00);
		chk8(outs_w, 8'h00);
		chk1(op_ready_o, 1'b1);
		rd(2'h3, 8'h00);
	endtask

	initial
	begin
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		#1;
		chk_reset();
		$display("test reset done");
		for (int i = 0; i < 26; i++)
		begin
			wr(2'h0, rows[i].pre);
			do_op(rows[i].op, rows[i].sel, rows[i].src);
			chk8(flags_o, rows[i].flags); // only the named flags move
			chk8(outs_w, {4'h0, rows[i].outs}); // pulses and halt
			if (rows[i].outs[3])
				chk8(wb_data_o, rows[i].wb); // written value
			@(posedge clk_i);
			#1;
			chk8(outs_w, 8'h00); // pulses last one cycle
		end
		$display("test table done");
		rd(2'h1, 8'hc3); // last written value
		rd(2'h2, 8'h0c); // sleep and restart were seen
		@(posedge clk_i);
		#1;
		chk8(bus_rdata_o, 8'h00);
		wr(2'h2, 8'h0c);
		rd(2'h2, 8'h00);
		$display("test registers done");
		wr(2'h0, 8'h00);
		@(posedge clk_i);
		op_valid_i <= 1'b1;
		op_i <= carry_raise_op;
		@(posedge clk_i);
		op_i <= overflow_flag_raise_op;
		#1;
		chk8(flags_o, 8'h01); // one cycle per op
		@(posedge clk_i);
		bus_wr_i <= 1'b1;
		bus_wdata_i <= 8'hff;
		op_i <= carry_drop_op;
		#1;
		chk8(flags_o, 8'h09); // back to back
		@(posedge clk_i);
		bus_wr_i <= 1'b0;
		op_valid_i <= 1'b0;
		#1;
		chk8(flags_o, 8'hfe); // op overrides same-cycle write
		@(posedge clk_i);
		en_i <= 1'b0;
		op_valid_i <= 1'b1;
		op_i <= carry_raise_op;
		repeat (2) @(posedge clk_i);
		en_i <= 1'b1;
		op_valid_i <= 1'b0;
		#1;
		chk8(flags_o, 8'hfe); // frozen while disabled
		$display("test sequencing done");
		wr(2'h3, 8'h01);
		rd(2'h3, 8'h01);
		do_op(debug_break_op, 3'h0, 8'h00);
		chk1(break_halt_o, 1'b1); // break with debug on
		chk1(op_ready_o, 1'b0);
		do_op(carry_raise_op, 3'h0, 8'h00);
		chk8(flags_o, 8'hfe); // halted core ignores ops
		rd(2'h2, 8'h12);
		@(posedge clk_i);
		dbg_resume_i <= 1'b1;
		@(posedge clk_i);
		dbg_resume_i <= 1'b0;
		#1;
		chk1(break_halt_o, 1'b0);
		chk1(op_ready_o, 1'b1);
		$display("test break done");
		@(posedge clk_i);
		resetn_i <= 1'b0;
		@(posedge clk_i);
		resetn_i <= 1'b1;
		#1;
		chk_reset();
		$display("test second reset done");
		conclude();
	end
endmodule
